// >>> rtl/meter_params.svh
// Constant definitions for the meter panel control sequencer
`ifndef METER_PARAMS_SVH
`define METER_PARAMS_SVH
// ***************************************
// Clock and timing
// ***************************************
`define CLK_MHZ      50
`define INT0_US      200
`define INT1_US      2000
`define INT2_US      20000
`define INT3_US      200000
`define INT4_US      2000000
`define FLASH_MS     250
// ***************************************
// Register map (byte addresses)
// ***************************************
`define REG_CTRL     4'h0
`define REG_STATUS   4'h4
`define REG_READING  4'h8
`define CTRL_FUNC    1:0
`define CTRL_TIME    4:2
`define CTRL_RATIO   5
`define CTRL_SINGLE  6
`define CTRL_TRIG    7
`define CTRL_RESET   32'h0000_0000
// ***************************************
// Ranging and display
// ***************************************
`define RANGE_UP     28'h0140000
`define RANGE_DOWN   28'h0012000
`define RANGE_MAX    3'h5
`define DIGITS       12
`define DP_POS       6
`define DIG_MINUS    4'hA
`define DIG_BLANK    4'hF
`define TEST_LAST    3'h5
`endif

// >>> rtl/meter_pkg.sv
// Types shared by the meter panel control sequencer
package meter_pkg;
   typedef enum logic [1:0] {FUNC_DCV, FUNC_ACV, FUNC_OHM} func_t;
   typedef enum {S_IDLE, S_CONV, S_HOLD} seq_state_t;
endpackage : meter_pkg

// >>> rtl/meter_panel_control_sequencer.sv
// Panel arbitration, sampling sequencer, autorange and display formatter
//
// Behaviour
// - Range up above 140000 counts
// - Range down below 12000 counts
// - Twelve positions, fixed point, reading shifts
// - Blank leading zeros except units digit
// - Minus sign left of top digit
// - Five times, scale three to seven nines
// - Function buttons: leftmost wins
// - Time buttons: leftmost wins
// - One-shot: changes wait for next press
// - Longer time lengthens every conversion
// - Panel changes ignored during conversion
// - Panel control: host ignored except lockout
// - Host control: host sets all but sampling
// - No interface unit: host select ignored
// - Lockout disables all panel controls
// - Self check: five tests, step advances
// - Fifth test shows eleven eights
// - External reference never with resistance
// - Repeat updates; one-shot holds reading
// - Busy marks invalid, blocks buttons
// - Lockout overrides panel-control selection
// - Overload flashes the display
//
// The implementer's own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ns
`include "meter_params.svh"
module meter_panel_control_sequencer #(
   parameter int unsigned INT_CYC0  = `INT0_US * `CLK_MHZ,
   parameter int unsigned INT_CYC1  = `INT1_US * `CLK_MHZ,
   parameter int unsigned INT_CYC2  = `INT2_US * `CLK_MHZ,
   parameter int unsigned INT_CYC3  = `INT3_US * `CLK_MHZ,
   parameter int unsigned INT_CYC4  = `INT4_US * `CLK_MHZ,
   parameter int unsigned FLASH_CYC = `FLASH_MS * `CLK_MHZ * 1000
) (
   input  wire logic          clk_i,
   input  wire logic          sys_rst_i,
   input  wire logic          wb_cyc_i,
   input  wire logic          wb_stb_i,
   input  wire logic          wb_we_i,
   input  wire logic [3:0]    wb_adr_i,
   input  wire logic [3:0]    wb_sel_i,
   input  wire logic [31:0]   wb_dat_i,
   output logic      [31:0]   wb_dat_o,
   output logic               wb_ack_o,
   input  wire logic [2:0]    btn_func_i,
   input  wire logic [4:0]    btn_time_i,
   input  wire logic          btn_local_i,
   input  wire logic          btn_remote_i,
   input  wire logic          btn_rep_i,
   input  wire logic          btn_single_i,
   input  wire logic          btn_test_i,
   input  wire logic          btn_step_i,
   input  wire logic          btn_ratio_i,
   input  wire logic          iface_present_i,
   input  wire logic          lockout_i,
   input  wire logic [27:0]   reading_bcd_i,
   input  wire logic          reading_neg_i,
   input  wire logic          overload_i,
   output meter_pkg::func_t   func_o,
   output logic      [2:0]    time_o,
   output logic               ratio_o,
   output logic      [2:0]    range_o,
   output logic               busy_o,
   output logic               remote_o,
   output logic               flash_o,
   output logic      [2:0]    test_step_o,
   output logic      [47:0]   digits_o
);
   import meter_pkg::*;

   // ***************************************
   // Helper functions
   // ***************************************
   // Leftmost asserted button index, bit n-1 is leftmost
   function automatic logic [2:0] pick_left(input logic [4:0] b,
                                            input int n);
      logic [2:0] r;
      r = 3'h0;
      for (int i = 0; i < 5; i++) begin
         if (i < n && b[n-1-i] && r == 3'h0) begin
            r = 3'(i + 1);
         end
      end
      return r;
   endfunction : pick_left

   function automatic logic [31:0] int_cycles(input logic [2:0] t);
      case (t)
         3'h0:    int_cycles = INT_CYC0;
         3'h1:    int_cycles = INT_CYC1;
         3'h2:    int_cycles = INT_CYC2;
         3'h3:    int_cycles = INT_CYC3;
         default: int_cycles = INT_CYC4;
      endcase
   endfunction : int_cycles

   // Reading LSD sits at position rng; scale keeps the top len+3 digits
   function automatic logic [47:0] fmt(input logic [27:0] r,
                                       input logic neg,
                                       input logic [2:0] rng,
                                       input logic [2:0] t);
      logic [47:0] d;
      logic [3:0]  nib;
      logic        lead;
      int          k;
      d = {`DIGITS{`DIG_BLANK}};
      lead = 1'b1;
      for (int p = `DIGITS - 1; p >= 0; p--) begin
         k = p - int'(rng);
         nib = `DIG_BLANK;
         if (k >= 7) begin
            nib = 4'h0;
         end else if (k >= 0 && k >= 4 - int'(t)) begin
            nib = r[k*4 +: 4];
         end
         if (lead && nib == 4'h0 && p > `DP_POS) begin
            nib = `DIG_BLANK;
         end else if (lead && nib != `DIG_BLANK) begin
            lead = 1'b0;
            if (neg && p < `DIGITS - 1) begin
               d[(p+1)*4 +: 4] = `DIG_MINUS;
            end
         end
         d[p*4 +: 4] = nib;
      end
      return d;
   endfunction : fmt

   // ***************************************
   // Pin synchronisers
   // ***************************************
   localparam int NSYNC = 17;
   logic [NSYNC-1:0] raw, sync1_q, sync2_q, prev_q;
   assign raw = {btn_func_i, btn_time_i, btn_local_i, btn_remote_i,
                 btn_rep_i, btn_single_i, btn_test_i, btn_step_i,
                 btn_ratio_i, iface_present_i, lockout_i};

   // Two stages ahead of all panel logic; prev_q only for edges
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sync1_q <= '0;
         sync2_q <= '0;
         prev_q  <= '0;
      end else begin
         sync1_q <= raw;
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
      end
   end

   logic [2:0] s_func;
   logic [4:0] s_time;
   logic       lockout, present, panel_ok, rise_local, rise_remote;
   logic       rise_rep, rise_single, rise_step, s_test, s_ratio;
   assign s_func      = sync2_q[16:14];
   assign s_time      = sync2_q[13:9];
   assign lockout     = sync2_q[0];
   assign present     = sync2_q[1];
   assign s_ratio     = sync2_q[2];
   assign s_test      = sync2_q[4];
   assign rise_step   = sync2_q[3] & ~prev_q[3];
   assign rise_single = sync2_q[5] & ~prev_q[5];
   assign rise_rep    = sync2_q[6] & ~prev_q[6];
   assign rise_remote = sync2_q[7] & ~prev_q[7];
   assign rise_local  = sync2_q[8] & ~prev_q[8];

   // ***************************************
   // Wishbone slave
   // ***************************************
   logic [31:0] ctrl_q;
   logic        trig_q, wb_hit, wb_wr;
   assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   // Write lands on the edge that sees ack, as the master expects
   assign wb_wr  = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

   // Control register write; trigger bit self-clears
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ctrl_q <= `CTRL_RESET;
         trig_q <= 1'b0;
      end else begin
         trig_q <= 1'b0;
         if (wb_wr && wb_adr_i == `REG_CTRL) begin
            if (wb_sel_i[0]) begin
               ctrl_q[7:0] <= {1'b0, wb_dat_i[6:0]};
               trig_q      <= wb_dat_i[`CTRL_TRIG];
            end
         end
      end
   end

   seq_state_t  state_q;
   logic [27:0] rd_q;
   logic        rd_neg_q, ovl_q, remote_sel_q, single_q;
   logic [2:0]  pend_time_q;
   func_t       pend_func_q;
   logic        pend_ratio_q;

   // Ack one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= wb_hit;
         wb_dat_o <= '0;
         if (wb_hit && !wb_we_i) begin
            case (wb_adr_i)
               `REG_CTRL:    wb_dat_o <= ctrl_q;
               `REG_STATUS:  wb_dat_o <= {15'h0, ovl_q, test_step_o,
                                          single_q, lockout, remote_o,
                                          range_o, time_o, ratio_o,
                                          func_o, busy_o};
               `REG_READING: wb_dat_o <= {rd_neg_q, 3'h0, rd_q};
               default:      wb_dat_o <= '0;
            endcase
         end
      end
   end

   // ***************************************
   // Control arbitration
   // ***************************************
   logic remote_act;
   // Lockout forces host ownership and beats the local choice
   assign remote_act = (remote_sel_q & present) | lockout;
   // Busy and lockout both block every push button
   assign panel_ok = ~lockout & ~busy_o;

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         remote_sel_q <= 1'b0;
      end else if (panel_ok) begin
         if (rise_remote) begin
            remote_sel_q <= 1'b1;
         end else if (rise_local) begin
            remote_sel_q <= 1'b0;
         end
      end
   end

   // Sample mode: panel owns it unless locked out
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         single_q <= 1'b0;
      end else if (lockout) begin
         single_q <= ctrl_q[`CTRL_SINGLE];
      end else if (panel_ok && rise_single) begin
         single_q <= 1'b1;
      end else if (panel_ok && rise_rep) begin
         single_q <= 1'b0;
      end
   end

   logic [2:0] fsel, tsel;
   assign fsel = pick_left({2'b00, s_func}, 3);
   assign tsel = pick_left(s_time, 5);

   // Pending settings; frozen while a conversion runs
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pend_func_q  <= FUNC_DCV;
         pend_time_q  <= 3'h0;
         pend_ratio_q <= 1'b0;
      end else if (!busy_o) begin
         if (remote_act) begin
            pend_func_q  <= func_t'(ctrl_q[`CTRL_FUNC] == 2'h3 ?
                                    2'h2 : ctrl_q[`CTRL_FUNC]);
            pend_time_q  <= ctrl_q[`CTRL_TIME] > 3'h4 ?
                            3'h4 : ctrl_q[`CTRL_TIME];
            pend_ratio_q <= ctrl_q[`CTRL_RATIO];
         end else begin
            if (fsel != 3'h0) begin
               pend_func_q <= func_t'(2'(fsel - 3'h1));
            end
            if (tsel != 3'h0) begin
               pend_time_q <= tsel - 3'h1;
            end
            pend_ratio_q <= s_ratio;
         end
      end
   end

   // ***************************************
   // Sampling sequencer
   // ***************************************
   logic [31:0] cnt_q;
   logic        trigger, start, capture;
   // Host trigger only counts while it owns sampling
   assign trigger = (panel_ok & rise_single) | (lockout & trig_q);
   // Leaving one-shot for repeat must restart the free-running loop
   assign start   = (state_q == S_IDLE) ||
                    (state_q == S_HOLD && (trigger || !single_q));
   assign capture = state_q == S_CONV && cnt_q == 32'h1;

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_q <= S_IDLE;
         cnt_q   <= 32'h0;
         busy_o  <= 1'b0;
      end else begin
         case (state_q)
            S_IDLE, S_HOLD: begin
               if (start) begin
                  state_q <= S_CONV;
                  cnt_q   <= int_cycles(pend_time_q);
                  busy_o  <= 1'b1;
               end
            end
            S_CONV: begin
               cnt_q <= cnt_q - 32'h1;
               if (capture) begin
                  state_q <= single_q ? S_HOLD : S_IDLE;
                  busy_o  <= 1'b0;
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // Settings take effect only as a conversion starts
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         func_o   <= FUNC_DCV;
         time_o   <= 3'h0;
         ratio_o  <= 1'b0;
         remote_o <= 1'b0;
      end else begin
         remote_o <= remote_act;
         if (start) begin
            func_o  <= pend_func_q;
            time_o  <= pend_time_q;
            ratio_o <= pend_ratio_q && pend_func_q != FUNC_OHM;
         end
      end
   end

   // ***************************************
   // Reading capture and autorange
   // ***************************************
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rd_q     <= 28'h0;
         rd_neg_q <= 1'b0;
         ovl_q    <= 1'b0;
         range_o  <= 3'h0;
      end else if (capture) begin
         rd_q     <= reading_bcd_i;
         rd_neg_q <= reading_neg_i;
         ovl_q    <= overload_i;
         if ((overload_i || reading_bcd_i > `RANGE_UP) &&
             range_o < `RANGE_MAX) begin
            range_o <= range_o + 3'h1;
         end else if (!overload_i && reading_bcd_i < `RANGE_DOWN &&
                      range_o != 3'h0) begin
            range_o <= range_o - 3'h1;
         end
      end
   end

   // ***************************************
   // Self check and display
   // ***************************************
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         test_step_o <= 3'h0;
      end else if (!s_test && !lockout) begin
         test_step_o <= 3'h0;
      end else if (panel_ok) begin
         if (test_step_o == 3'h0) begin
            test_step_o <= 3'h1;
         end else if (rise_step && test_step_o != `TEST_LAST) begin
            test_step_o <= test_step_o + 3'h1;
         end
      end
   end

   // Blink timer runs free; only gated by the overload flag
   logic [31:0] blink_q;
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         blink_q <= 32'h0;
         flash_o <= 1'b0;
      end else begin
         blink_q <= (blink_q >= FLASH_CYC - 1) ? 32'h0 : blink_q + 32'h1;
         if (!ovl_q) begin
            flash_o <= 1'b0;
         end else if (blink_q == 32'h0) begin
            flash_o <= ~flash_o;
         end
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         digits_o <= {`DIGITS{`DIG_BLANK}};
      end else if (test_step_o == `TEST_LAST) begin
         digits_o <= {`DIG_BLANK, {11{4'h8}}};
      end else begin
         digits_o <= fmt(rd_q, rd_neg_q, range_o, time_o);
      end
   end

   // ***************************************
   // Assertions
   // ***************************************
   property p_range_up;
      @(posedge clk_i) disable iff (sys_rst_i)
      capture && reading_bcd_i > `RANGE_UP && range_o < `RANGE_MAX
      |=> range_o == $past(range_o) + 3'h1;
   endproperty
   a_range_up: assert property (p_range_up)
      else $error("range did not step up");

   property p_range_down;
      @(posedge clk_i) disable iff (sys_rst_i)
      capture && !overload_i && reading_bcd_i < `RANGE_DOWN &&
      range_o != 3'h0 |=> range_o == $past(range_o) - 3'h1;
   endproperty
   a_range_down: assert property (p_range_down)
      else $error("range did not step down");

   property p_range_hold;
      @(posedge clk_i) disable iff (sys_rst_i)
      !capture |=> $stable(range_o);
   endproperty
   a_range_hold: assert property (p_range_hold)
      else $error("range moved outside a capture");

   property p_busy_freeze;
      @(posedge clk_i) disable iff (sys_rst_i)
      busy_o && !capture |=> $stable(func_o) && $stable(time_o)
                             && $stable(pend_func_q);
   endproperty
   a_busy_freeze: assert property (p_busy_freeze)
      else $error("settings changed during conversion");

   property p_ratio_ohm;
      @(posedge clk_i) disable iff (sys_rst_i)
      func_o == FUNC_OHM |-> !ratio_o;
   endproperty
   a_ratio_ohm: assert property (p_ratio_ohm)
      else $error("external reference with resistance");

   property p_full_house;
      @(posedge clk_i) disable iff (sys_rst_i)
      test_step_o == `TEST_LAST |=> digits_o[43:0] == {11{4'h8}};
   endproperty
   a_full_house: assert property (p_full_house)
      else $error("display test not all eights");

   property p_func_left;
      @(posedge clk_i) disable iff (sys_rst_i)
      !busy_o && !remote_act && s_func[2] && (s_func[1] || s_func[0])
      |=> pend_func_q == FUNC_DCV;
   endproperty
   a_func_left: assert property (p_func_left)
      else $error("function priority wrong");

   property p_lockout_remote;
      @(posedge clk_i) disable iff (sys_rst_i)
      lockout ##1 lockout |-> remote_o && $stable(test_step_o);
   endproperty
   a_lockout_remote: assert property (p_lockout_remote)
      else $error("panel active under lockout");

   property p_single_hold;
      @(posedge clk_i) disable iff (sys_rst_i)
      state_q == S_HOLD && single_q && !trigger
      |=> state_q == S_HOLD && !busy_o;
   endproperty
   a_single_hold: assert property (p_single_hold)
      else $error("one-shot reading not held");

   property p_conv_len;
      @(posedge clk_i) disable iff (sys_rst_i)
      $rose(busy_o) && time_o != 3'h0 |-> busy_o [*2];
   endproperty
   a_conv_len: assert property (p_conv_len)
      else $error("conversion ended too soon");

   c_repeat:   cover property (@(posedge clk_i) capture && !single_q);
   c_single:   cover property (@(posedge clk_i)
                               state_q == S_HOLD && trigger);
   c_selftest: cover property (@(posedge clk_i)
                               test_step_o == `TEST_LAST);
   c_range_up: cover property (@(posedge clk_i)
                               capture && reading_bcd_i > `RANGE_UP);
endmodule : meter_panel_control_sequencer

// >>> bench/panel_model.sv
// Model of the front panel push buttons and the optional interface unit
`timescale 1ns/1ns
module panel_model (
   input  wire logic       clk_i,
   output logic      [2:0] func_o,
   output logic      [4:0] time_o,
   output logic      [4:0] mom_o,
   output logic            test_o,
   output logic            ratio_o,
   output logic            iface_o,
   output logic            lockout_o
);
   // ***************************************
   // Button levels and presses
   // ***************************************
   // Latching groups start on the leftmost choice, like a fresh panel
   initial begin
      func_o = 3'h4;
      time_o = 5'h10;
      mom_o = 5'h00;
      {test_o, ratio_o, iface_o, lockout_o} = 4'h0;
   end
   // Levels change just after an edge, then stand until the next call
   task automatic set(input logic [2:0] f,
                      input logic [4:0] t,
                      input logic [3:0] lv);
      @(posedge clk_i);
      func_o <= f;
      time_o <= t;
      {test_o, ratio_o, iface_o, lockout_o} <= lv;
   endtask : set
   // Momentary press; no feedback from the panel, so callers retry
   task automatic push(input int b);
      @(posedge clk_i);
      mom_o[b] <= 1'b1;
      repeat (4) @(posedge clk_i);
      mom_o[b] <= 1'b0;
      repeat (4) @(posedge clk_i);
   endtask : push
endmodule : panel_model

// >>> bench/meter_panel_control_sequencer_tb.sv
// Self-checking bench for the meter panel control sequencer
`timescale 1ns/1ns
`define CHK(nm, exp, got) \
   begin \
      comparisons++; \
      if ((got) !== (exp)) begin \
         failures++; \
         $display("[ERR] %s exp %h got %h", nm, exp, got); \
      end \
   end
module meter_panel_control_sequencer_tb;
   import meter_pkg::*;
   // ***************************************
   // Signals and tables
   // ***************************************
   logic        clk, rst, cyc, stb, we, ack, rd_neg, ovl, f;
   logic [3:0]  adr, sel, wsel;
   logic [31:0] wdat, rdat, rv;
   logic [27:0] rd_bcd;
   logic [2:0]  bfunc, tim, rng, step;
   logic [4:0]  btime, mom;
   logic        btest, bratio, iface, lock;
   logic        ratio, busy, remote, flash;
   logic [47:0] digits;
   func_t       func;
   int          failures, comparisons, n;
   // Readings that straddle both thresholds, and the range expected after
   logic [27:0] rtab [5] = '{28'h9999999, 28'h0140000, 28'h0011999,
                             28'h0012000, 28'h0140001};
   logic [2:0]  etab [5] = '{3'h1, 3'h1, 3'h0, 3'h0, 3'h1};

   // Short counts keep each conversion a few cycles long
   meter_panel_control_sequencer #(
      .INT_CYC0(4), .INT_CYC1(6), .INT_CYC2(8), .INT_CYC3(10),
      .INT_CYC4(12), .FLASH_CYC(8)
   ) u_dut (
      .clk_i(clk), .sys_rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .btn_func_i(bfunc),
      .btn_time_i(btime), .btn_local_i(mom[4]), .btn_remote_i(mom[3]),
      .btn_rep_i(mom[2]), .btn_single_i(mom[1]), .btn_test_i(btest),
      .btn_step_i(mom[0]), .btn_ratio_i(bratio), .iface_present_i(iface),
      .lockout_i(lock), .reading_bcd_i(rd_bcd), .reading_neg_i(rd_neg),
      .overload_i(ovl), .func_o(func), .time_o(tim), .ratio_o(ratio),
      .range_o(rng), .busy_o(busy), .remote_o(remote), .flash_o(flash),
      .test_step_o(step), .digits_o(digits)
   );
   // Momentary bits: 4 local, 3 remote, 2 repeat, 1 single, 0 step
   panel_model u_panel (
      .clk_i(clk), .func_o(bfunc), .time_o(btime), .mom_o(mom),
      .test_o(btest), .ratio_o(bratio), .iface_o(iface), .lockout_o(lock)
   );

   // ***************************************
   // Clock, tasks and verdict
   // ***************************************
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Classic single cycle; waits up to 50 cycles for ack, then flags it
   task automatic wb(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      {cyc, stb, we} <= {2'h3, w};
      adr <= a;
      sel <= wsel;
      wdat <= d;
      do begin
         @(posedge clk);
         k++;
      end while (ack !== 1'b1 && k < 50);
      rv = rdat;
      if (k >= 50)
         `CHK("ack", 1'b1, ack)
      {cyc, stb, we} <= 3'h0;
   endtask : wb
   // Bounded wait for the busy level
   task automatic wait_busy(input logic v);
      int k;
      k = 0;
      while (busy !== v && k < 400) begin
         @(posedge clk);
         k++;
      end
      if (k >= 400)
         `CHK("busy wait", v, busy)
   endtask : wait_busy
   // One host-triggered conversion in single mode, display settled after
   task automatic convert(input logic [27:0] b, input logic s,
                          input logic o);
      @(posedge clk);
      rd_bcd <= b;
      rd_neg <= s;
      ovl <= o;
      wb(1'b1, 4'h0, 32'h0000_00C0);
      wait_busy(1'b1);
      wait_busy(1'b0);
      repeat (2) @(posedge clk);
   endtask : convert
   task automatic summarize;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize
   // Whole run is about a thousand cycles; this is far beyond it
   initial begin
      #1_000_000;
      `CHK("watchdog", 1'b1, 1'b0)
      summarize();
   end

   // ***************************************
   // Test sequence
   // ***************************************
   initial begin
      {cyc, stb, we, rd_neg, ovl} = 5'h00;
      {adr, sel, wdat, rd_bcd} = '0;
      wsel = 4'hF;
      failures = 0;
      comparisons = 0;
      rst = 1'b1;
      repeat (8) @(posedge clk);
      `CHK("rst digits", 48'hFFFF_FFFF_FFFF, digits)
      `CHK("rst busy", 1'b0, busy)
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      `CHK("busy start", 1'b1, busy)
      // Trigger bit reads back as zero; unmapped reads zero
      wb(1'b1, 4'h0, 32'h0000_00C5);
      wb(1'b0, 4'h0, 32'h0);
      `CHK("ctrl", 8'h45, rv[7:0])
      // Lane 0 disabled: the write must be dropped
      wsel = 4'h0;
      wb(1'b1, 4'h0, 32'h0000_0001);
      wsel = 4'hF;
      wb(1'b0, 4'h0, 32'h0);
      `CHK("sel", 8'h45, rv[7:0])
      wb(1'b0, 4'hC, 32'h0);
      `CHK("unmapped", 32'h0, rv)
      // Two buttons forced in at once, resistance alone on the last pass; ratio asked for throughout
      for (int i = 0; i < 3; i++) begin
         u_panel.set(3'h4 >> i | 3'h1, 5'h10, 4'h4);
         repeat (40) @(posedge clk);
         `CHK("func", 2'(i), func)
         `CHK("ratio", i != 2, ratio)
      end
      // Every time choice, with a lower button also held except for the lowest choice
      for (int i = 0; i < 5; i++) begin
         u_panel.set(3'h4, 5'h10 >> i | 5'h01, 4'h0);
         repeat (40) @(posedge clk);
         wait_busy(1'b0);
         wait_busy(1'b1);
         n = 0;
         while (busy === 1'b1 && n < 99) begin
            n++;
            @(posedge clk);
         end
         `CHK("time", 3'(i), tim)
         `CHK("conv len", 4 + 2 * i, n)
      end
      // Lockout: host single mode, panel asks for resistance in vain
      u_panel.set(3'h1, 5'h10, 4'h3);
      wb(1'b1, 4'h0, 32'h0000_0040);
      repeat (40) @(posedge clk);
      convert(28'h0, 1'b0, 1'b0);
      `CHK("lock func", FUNC_DCV, func)
      `CHK("zeros", 48'hFFFF_F000_FFFF, digits)
      convert(28'h0, 1'b1, 1'b0);
      `CHK("minus", 48'hFFFF_A000_FFFF, digits)
      for (int i = 0; i < 5; i++) begin
         convert(rtab[i], 1'b0, 1'b0);
         `CHK("range", etab[i], rng)
         repeat (12) @(posedge clk);
         `CHK("held", 1'b0, busy)
      end
      convert(28'h0012000, 1'b0, 1'b1);
      `CHK("ovl range", 3'h2, rng)
      f = flash;
      repeat (8) @(posedge clk);
      `CHK("flash", ~f, flash)
      convert(28'h0012000, 1'b0, 1'b0);
      `CHK("no flash", 1'b0, flash)
      // Host control, first with no interface unit fitted
      u_panel.set(3'h4, 5'h10, 4'h0);
      repeat (10) u_panel.push(3);
      `CHK("no iface", 1'b0, remote)
      u_panel.set(3'h4, 5'h10, 4'h2);
      for (n = 0; n < 20 && remote !== 1'b1; n++)
         u_panel.push(3);
      wb(1'b1, 4'h0, 32'h0000_0009);
      u_panel.push(1);
      repeat (40) @(posedge clk);
      `CHK("host func", FUNC_ACV, func)
      `CHK("host time", 3'h2, tim)
      for (n = 0; n < 20 && remote !== 1'b0; n++)
         u_panel.push(4);
      u_panel.push(1);
      repeat (40) @(posedge clk);
      `CHK("panel func", FUNC_DCV, func)
      // Self check through all five tests
      u_panel.set(3'h4, 5'h10, 4'h8);
      repeat (10) @(posedge clk);
      `CHK("test", 3'h1, step)
      for (int k = 2; k < 6; k++) begin
         for (n = 0; n < 20 && step !== 3'(k); n++)
            u_panel.push(0);
         `CHK("step", 3'(k), step)
      end
      repeat (40) @(posedge clk);
      `CHK("eights", 48'hF888_8888_8888, digits)
      // Repeat press out of a held reading restarts conversions
      u_panel.push(2);
      wait_busy(1'b1);
      wait_busy(1'b0);
      wait_busy(1'b1);
      wb(1'b0, 4'h4, 32'h0);
      `CHK("rep mode", 1'b0, rv[12])
      summarize();
   end
endmodule : meter_panel_control_sequencer_tb
